// File: design/carf_map.svh
`ifndef CARF_MAP_SVH
`define CARF_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CARF_OFF_CTRL     8'h00
`define CARF_OFF_BPC0     8'h04
`define CARF_OFF_FEN      8'h14
`define CARF_OFF_MSEL_LO  8'h18
`define CARF_OFF_MSEL_HI  8'h1c
`define CARF_OFF_BPTR0    8'h20
`define CARF_OFF_BPTR_END 8'h30
`define CARF_OFF_FILT0    8'h40
`define CARF_OFF_MASK0    8'hc0
`define CARF_OFF_STAT     8'hd8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CARF_ALIGN        1:0
`define CARF_WORD_IDX     3:2
`define CARF_FILT_IDX     6:3
`define CARF_MASK_IDX     4:3
`define CARF_EXT_SEL      2
`define CARF_BIT_ABORT    12
`define CARF_BIT_TXSEL    7
`define CARF_BIT_SENDREQ  3
`define CARF_BIT_AUTORTR  2
`define CARF_PRIO         1:0
`define CARF_SID          15:5
`define CARF_BIT_TYPE     3
`define CARF_EIDHI        1:0
`define CARF_EIDLO        15:0
`define CARF_ST_BUSY      0
`define CARF_ST_BIDX      3:1
`define CARF_ST_DMA       4
`define CARF_ST_DBUF      8:5
`define CARF_ST_DROP      9
`define CARF_ST_ABORT     10

// ----------------------------------------------------------------
// Sizes, codes and constants
// ----------------------------------------------------------------
`define CARF_NFILT        16
`define CARF_NMASK        3
`define CARF_NTX          8
`define CARF_MSK_RSVD     2'b11
`define CARF_BUF_FIFO     4'hf
`define CARF_WORDS_LOG    3
`define CARF_RESP_OKAY    2'b00
`define CARF_RESP_SLVERR  2'b10
`endif

// File: design/carf_pkg.sv
`include "carf_map.svh"
package carf_pkg;

  // Whole state of the controller, registered in one process.
  typedef struct packed {
    logic                           ctrl_abort;
    logic [`CARF_NTX-1:0]           txsel;
    logic [`CARF_NTX-1:0]           autortr;
    logic [`CARF_NTX-1:0][1:0]      prio;
    logic [`CARF_NTX-1:0]           send_req;
    logic [`CARF_NFILT-1:0]         fen;
    logic [`CARF_NFILT-1:0][1:0]    msel;
    logic [`CARF_NFILT-1:0][3:0]    bptr;
    logic [`CARF_NFILT-1:0][10:0]   fsid;
    logic [`CARF_NFILT-1:0]         fexide;
    logic [`CARF_NFILT-1:0][17:0]   feid;
    logic [`CARF_NMASK-1:0][10:0]   msid;
    logic [`CARF_NMASK-1:0]         type_enforce;
    logic [`CARF_NMASK-1:0][17:0]   meid;
    logic                           busy;
    logic [2:0]                     busy_idx;
    logic                           asm_valid;
    logic                           asm_ide;
    logic                           asm_rtr;
    logic [10:0]                    asm_sid;
    logic [17:0]                    asm_eid;
    logic                           dma_req;
    logic [3:0]                     dma_buf;
    logic [3:0]                     dma_filter;
    logic                           dropped;
    logic                           aw_held;
    logic [7:0]                     aw_addr;
    logic                           w_held;
    logic [31:0]                    w_data;
    logic [3:0]                     w_strb;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic                           rvalid;
    logic [31:0]                    rdata;
    logic [1:0]                     rresp;
  } carf_state_t;

endpackage

// File: design/carf_top.sv
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "carf_map.svh"
module carf_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        rx_valid,
  input  wire logic        rx_ide,
  input  wire logic        rx_rtr,
  input  wire logic [10:0] rx_sid,
  input  wire logic [17:0] rx_eid,
  input  wire logic [15:0] rx_buf_full,
  input  wire logic        tx_start,
  input  wire logic [2:0]  tx_start_idx,
  input  wire logic        tx_done,
  input  wire logic        tx_done_ok,
  output logic [7:0]       send_pending,
  output logic [15:0]      tx_priority,
  output logic             dma_req,
  input  wire logic        dma_ack,
  output logic [3:0]       dma_buf,
  output logic [3:0]       dma_filter,
  output logic [7:0]       dma_word_base
);
  import carf_pkg::*;

  carf_pkg::carf_state_t s;
  carf_pkg::carf_state_t next_s;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  // Returns {hit, data}; unaligned or unmapped addresses miss.
  function automatic logic [32:0] rd_word(input carf_state_t st, input logic [7:0] a);
    logic [31:0] d;
    logic        hit;
    logic [7:0]  off;
    d   = 32'h0;
    hit = 1'b1;
    off = 8'h0;
    if (a[`CARF_ALIGN] != 2'b00) begin
      hit = 1'b0;
    end else if (a == `CARF_OFF_CTRL) begin
      d[`CARF_BIT_ABORT] = st.ctrl_abort;
    end else if (a >= `CARF_OFF_BPC0 && a < `CARF_OFF_FEN) begin
      off = a - `CARF_OFF_BPC0;
      for (int j = 0; j < 2; j++) begin
        d[8*j+`CARF_BIT_TXSEL]   = st.txsel[{off[`CARF_WORD_IDX], j[0]}];
        d[8*j+`CARF_BIT_SENDREQ] = st.send_req[{off[`CARF_WORD_IDX], j[0]}];
        d[8*j+`CARF_BIT_AUTORTR] = st.autortr[{off[`CARF_WORD_IDX], j[0]}];
        d[8*j+:2]                = st.prio[{off[`CARF_WORD_IDX], j[0]}];
      end
    end else if (a == `CARF_OFF_FEN) begin
      d[15:0] = st.fen;
    end else if (a == `CARF_OFF_MSEL_LO) begin
      d[15:0] = st.msel[7:0];
    end else if (a == `CARF_OFF_MSEL_HI) begin
      d[15:0] = st.msel[15:8];
    end else if (a >= `CARF_OFF_BPTR0 && a < `CARF_OFF_BPTR_END) begin
      off = a - `CARF_OFF_BPTR0;
      for (int j = 0; j < 4; j++) begin
        d[4*j+:4] = st.bptr[{off[`CARF_WORD_IDX], j[1:0]}];
      end
    end else if (a >= `CARF_OFF_FILT0 && a < `CARF_OFF_MASK0) begin
      off = a - `CARF_OFF_FILT0;
      if (off[`CARF_EXT_SEL]) begin
        d[`CARF_EIDLO] = st.feid[off[`CARF_FILT_IDX]][15:0];
      end else begin
        d[`CARF_SID]      = st.fsid[off[`CARF_FILT_IDX]];
        d[`CARF_BIT_TYPE] = st.fexide[off[`CARF_FILT_IDX]];
        d[`CARF_EIDHI]    = st.feid[off[`CARF_FILT_IDX]][17:16];
      end
    end else if (a >= `CARF_OFF_MASK0 && a < `CARF_OFF_STAT) begin
      off = a - `CARF_OFF_MASK0;
      if (off[`CARF_EXT_SEL]) begin
        d[`CARF_EIDLO] = st.meid[off[`CARF_MASK_IDX]][15:0];
      end else begin
        d[`CARF_SID]      = st.msid[off[`CARF_MASK_IDX]];
        d[`CARF_BIT_TYPE] = st.type_enforce[off[`CARF_MASK_IDX]];
        d[`CARF_EIDHI]    = st.meid[off[`CARF_MASK_IDX]][17:16];
      end
    end else if (a == `CARF_OFF_STAT) begin
      d[`CARF_ST_BUSY]  = st.busy;
      d[`CARF_ST_BIDX]  = st.busy_idx;
      d[`CARF_ST_DMA]   = st.dma_req;
      d[`CARF_ST_DBUF]  = st.dma_buf;
      d[`CARF_ST_DROP]  = st.dropped;
      d[`CARF_ST_ABORT] = st.ctrl_abort;
    end else begin
      hit = 1'b0;
    end
    return {hit, d};
  endfunction

  // ----------------------------------------------------------------
  // Bus handshakes and outputs
  // ----------------------------------------------------------------
  // Ready terms come straight from state; data outputs are flops.
  assign awready       = !s.aw_held && !s.bvalid;
  assign wready        = !s.w_held && !s.bvalid;
  assign arready       = !s.rvalid;
  assign bvalid        = s.bvalid;
  assign bresp         = s.bresp;
  assign rvalid        = s.rvalid;
  assign rdata         = s.rdata;
  assign rresp         = s.rresp;
  assign send_pending  = s.send_req & s.txsel;
  assign tx_priority   = s.prio;
  assign dma_req       = s.dma_req;
  assign dma_buf       = s.dma_buf;
  assign dma_filter    = s.dma_filter;
  assign dma_word_base = {1'b0, s.dma_buf, {`CARF_WORDS_LOG{1'b0}}};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Order of updates sets priority: hardware clears first, then
  // software writes, then hardware sets, so no set is lost except the
  // busy set by tx_start, which comes before the tx_done clear.
  always_comb begin
    logic        aw_now;
    logic        w_now;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic [32:0] cur;
    logic [31:0] v;
    logic [7:0]  off;
    logic [2:0]  b;
    logic [1:0]  m;
    logic        id_ok;
    logic        type_ok;
    logic        hit;
    logic        is_tx;
    logic        found;
    logic        win_rtr;
    logic [3:0]  win_f;
    logic [3:0]  win_bp;
    aw_now  = 1'b0;
    w_now   = 1'b0;
    wa      = 8'h0;
    wd      = 32'h0;
    ws      = 4'h0;
    cur     = 33'h0;
    v       = 32'h0;
    off     = 8'h0;
    b       = 3'h0;
    m       = 2'b00;
    id_ok   = 1'b0;
    type_ok = 1'b0;
    hit     = 1'b0;
    is_tx   = 1'b0;
    found   = 1'b0;
    win_rtr = 1'b0;
    win_f   = 4'h0;
    win_bp  = 4'h0;
    next_s  = s;

    // Read channel: one read at a time, answered a cycle later.
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && !s.rvalid) begin
      cur           = rd_word(s, araddr);
      next_s.rvalid = 1'b1;
      next_s.rdata  = cur[31:0];
      next_s.rresp  = cur[32] ? `CARF_RESP_OKAY : `CARF_RESP_SLVERR;
    end

    // Write channels: address and data may come in either order.
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    aw_now = s.aw_held || (awvalid && !s.bvalid);
    w_now  = s.w_held || (wvalid && !s.bvalid);
    if (awvalid && awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end

    // Transmit engine status; a frame seen starting is protected.
    if (tx_start) begin
      next_s.busy     = 1'b1;
      next_s.busy_idx = tx_start_idx;
    end
    if (tx_done && s.busy) begin
      next_s.busy = 1'b0;
      if (tx_done_ok) begin
        next_s.send_req[s.busy_idx] = 1'b0;
      end
    end

    // Abort-all sweeps every idle request; stays up until the
    // frame in flight has finished, then drops by itself.
    if (s.ctrl_abort) begin
      for (int i = 0; i < `CARF_NTX; i++) begin
        if (!(s.busy && s.busy_idx == i[2:0])) begin
          next_s.send_req[i] = 1'b0;
        end
      end
      if (!s.busy) begin
        next_s.ctrl_abort = 1'b0;
      end
    end

    if (s.dma_req && dma_ack) begin
      next_s.dma_req = 1'b0;
    end

    // Register write, merged byte by byte with the current value.
    if (aw_now && w_now) begin
      wa = s.aw_held ? s.aw_addr : awaddr;
      wd = s.w_held ? s.w_data : wdata;
      ws = s.w_held ? s.w_strb : wstrb;
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      cur            = rd_word(s, wa);
      next_s.bresp   = cur[32] ? `CARF_RESP_OKAY : `CARF_RESP_SLVERR;
      for (int j = 0; j < 4; j++) begin
        v[8*j+:8] = ws[j] ? wd[8*j+:8] : cur[8*j+:8];
      end
      if (!cur[32]) begin
        v = 32'h0;
      end else if (wa == `CARF_OFF_CTRL) begin
        if (v[`CARF_BIT_ABORT]) begin
          next_s.ctrl_abort = 1'b1;
        end
      end else if (wa >= `CARF_OFF_BPC0 && wa < `CARF_OFF_FEN) begin
        off = wa - `CARF_OFF_BPC0;
        for (int j = 0; j < 2; j++) begin
          b = {off[`CARF_WORD_IDX], j[0]};
          next_s.txsel[b]   = v[8*j+`CARF_BIT_TXSEL];
          next_s.autortr[b] = v[8*j+`CARF_BIT_AUTORTR];
          next_s.prio[b]    = v[8*j+:2];
          if (v[8*j+`CARF_BIT_SENDREQ]) begin
            next_s.send_req[b] = 1'b1;
          end else if (!(s.busy && s.busy_idx == b)) begin
            next_s.send_req[b] = 1'b0;
          end
        end
      end else if (wa == `CARF_OFF_FEN) begin
        next_s.fen = v[15:0];
      end else if (wa == `CARF_OFF_MSEL_LO) begin
        next_s.msel[7:0] = v[15:0];
      end else if (wa == `CARF_OFF_MSEL_HI) begin
        next_s.msel[15:8] = v[15:0];
      end else if (wa >= `CARF_OFF_BPTR0 && wa < `CARF_OFF_BPTR_END) begin
        off = wa - `CARF_OFF_BPTR0;
        for (int j = 0; j < 4; j++) begin
          next_s.bptr[{off[`CARF_WORD_IDX], j[1:0]}] = v[4*j+:4];
        end
      end else if (wa >= `CARF_OFF_FILT0 && wa < `CARF_OFF_MASK0) begin
        off = wa - `CARF_OFF_FILT0;
        if (off[`CARF_EXT_SEL]) begin
          next_s.feid[off[`CARF_FILT_IDX]][15:0] = v[`CARF_EIDLO];
        end else begin
          next_s.fsid[off[`CARF_FILT_IDX]]         = v[`CARF_SID];
          next_s.fexide[off[`CARF_FILT_IDX]]       = v[`CARF_BIT_TYPE];
          next_s.feid[off[`CARF_FILT_IDX]][17:16]  = v[`CARF_EIDHI];
        end
      end else if (wa >= `CARF_OFF_MASK0 && wa < `CARF_OFF_STAT) begin
        off = wa - `CARF_OFF_MASK0;
        if (off[`CARF_EXT_SEL]) begin
          next_s.meid[off[`CARF_MASK_IDX]][15:0] = v[`CARF_EIDLO];
        end else begin
          next_s.msid[off[`CARF_MASK_IDX]]        = v[`CARF_SID];
          next_s.type_enforce[off[`CARF_MASK_IDX]]        = v[`CARF_BIT_TYPE];
          next_s.meid[off[`CARF_MASK_IDX]][17:16] = v[`CARF_EIDHI];
        end
      end else if (wa == `CARF_OFF_STAT) begin
        if (v[`CARF_ST_DROP]) begin
          next_s.dropped = 1'b0;
        end
      end
    end

    next_s.asm_valid = rx_valid;
    if (rx_valid) begin
      next_s.asm_ide = rx_ide;
      next_s.asm_rtr = rx_rtr;
      next_s.asm_sid = rx_sid;
      next_s.asm_eid = rx_eid;
    end

    // Filter pass over the captured frame. Scanning downwards leaves
    // the lowest usable filter as winner.
    if (s.asm_valid) begin
      for (int f = `CARF_NFILT - 1; f >= 0; f--) begin
        m = s.msel[f];
        id_ok = (m != `CARF_MSK_RSVD) && ((s.msid[m] & (s.fsid[f] ^ s.asm_sid)) == 11'h0);
        if (s.asm_ide && ((s.meid[m] & (s.feid[f] ^ s.asm_eid)) != 18'h0)) begin
          id_ok = 1'b0;
        end
        type_ok = !s.type_enforce[m] || (s.fexide[f] == s.asm_ide);
        hit = s.fen[f] && id_ok && type_ok;
        is_tx = (s.bptr[f][3] == 1'b0) && s.txsel[s.bptr[f][2:0]];
        if (hit && is_tx && s.autortr[s.bptr[f][2:0]] && s.asm_rtr) begin
          found   = 1'b1;
          win_rtr = 1'b1;
          win_f   = f[3:0];
          win_bp  = s.bptr[f];
        end else if (hit && !is_tx && (s.bptr[f] == `CARF_BUF_FIFO || !rx_buf_full[s.bptr[f]])) begin
          found   = 1'b1;
          win_rtr = 1'b0;
          win_f   = f[3:0];
          win_bp  = s.bptr[f];
        end
      end
      if (found && win_rtr) begin
        next_s.send_req[win_bp[2:0]] = 1'b1;
      end else if (found) begin
        if (s.dma_req && !dma_ack) begin
          next_s.dropped = 1'b1;
        end else begin
          next_s.dma_req    = 1'b1;
          next_s.dma_buf    = win_bp;
          next_s.dma_filter = win_f;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset clears all control state to zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// File: sim/can_abort_rtr_accept_filter_bench.sv
`timescale 1ns/1ps
`include "carf_map.svh"
module can_abort_rtr_accept_filter_bench;
  import carf_pkg::*;
  localparam logic [3:0] msk_hit = 4'b0110;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready, rx_valid, rx_ide, rx_rtr, tx_start, tx_done, tx_done_ok, dma_req, dma_ack;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  tx_start_idx, prot;
  logic [3:0]  dma_buf, dma_filter, wstrb;
  logic [7:0]  awaddr, araddr, send_pending, dma_word_base;
  logic [10:0] rx_sid;
  logic [15:0] rx_buf_full, tx_priority;
  logic [17:0] rx_eid;
  logic [31:0] wdata, rdata, rd;
  int          miscompares = 0, n_checks = 0, cycles = 0;
  // ----------------------------------------------------------------
  // Design, far side, clock and tasks
  // ----------------------------------------------------------------
  carf_top dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(prot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(prot), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .rx_valid(rx_valid), .rx_ide(rx_ide), .rx_rtr(rx_rtr),
    .rx_sid(rx_sid), .rx_eid(rx_eid), .rx_buf_full(rx_buf_full), .tx_start(tx_start),
    .tx_start_idx(tx_start_idx), .tx_done(tx_done), .tx_done_ok(tx_done_ok), .send_pending(send_pending),
    .tx_priority(tx_priority), .dma_req(dma_req), .dma_ack(dma_ack), .dma_buf(dma_buf),
    .dma_filter(dma_filter), .dma_word_base(dma_word_base));
  carf_node node (.aclk(aclk), .rx_valid(rx_valid), .rx_ide(rx_ide), .rx_rtr(rx_rtr), .rx_sid(rx_sid),
    .rx_eid(rx_eid), .tx_start(tx_start), .tx_start_idx(tx_start_idx), .tx_done(tx_done),
    .tx_done_ok(tx_done_ok));
  // A 25 ns clock; the cycle count cuts a hang short.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Handshakes are judged at the falling edge, where ready has settled.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, hit;
    {ta, tw, hit} = '0;
    @(posedge aclk);
    {awvalid, wvalid, bready, awaddr, wdata} <= {3'b111, a, d};
    while (!(ta && tw)) begin
      @(negedge aclk);
      {ta, tw} = {ta || awready, tw || wready};
      @(posedge aclk);
      {awvalid, wvalid} <= {!ta, !tw};
    end
    while (!hit) begin
      @(negedge aclk);
      {hit, resp} = {bvalid, bresp};
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    logic ta, hit;
    {ta, hit} = '0;
    @(posedge aclk);
    {arvalid, rready, araddr} <= {2'b11, a};
    while (!hit) begin
      @(negedge aclk);
      {hit, rd, resp} = {rvalid, rdata, rresp};
      ta = ta || arready;
      @(posedge aclk);
      arvalid <= !ta;
    end
    rready <= 1'b0;
  endtask
  // A frame, then the storage request two edges later, acknowledged at once.
  task automatic rx(input logic ide, input logic rtr, input logic [10:0] sid, input logic [17:0] eid,
                    input logic ex, input logic [3:0] eb, input logic [3:0] ef);
    node.frame(ide, rtr, sid, eid);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("dma_req", ex, dma_req);
    if (ex) begin
      chk("dma_buf", eb, dma_buf);
      chk("dma_filter", ef, dma_filter);
      chk("dma_word_base", {eb, 3'b000}, dma_word_base);
      @(posedge aclk);
      dma_ack <= 1'b1;
      @(posedge aclk);
      dma_ack <= 1'b0;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence: reset, filters, masks, remote answer, aborts.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, dma_ack} = '0;
    {awaddr, araddr, wdata, rx_buf_full} = '0;
    {prot, wstrb} = 7'h0f;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(`CARF_OFF_FEN);
    chk("filter_enable_bits", 32'h0, rd);
    rd_reg(8'hfc);
    chk("unmapped rresp", 2'b10, resp);
    wr_reg(`CARF_OFF_MASK0, 32'hffe0);
    wr_reg(`CARF_OFF_MASK0 + 8'h04, 32'hffff);
    wr_reg(`CARF_OFF_FILT0, 32'h2460);
    wr_reg(`CARF_OFF_FILT0 + 8'h04, 32'h1234);
    wr_reg(`CARF_OFF_FILT0 + 8'h08, 32'h2460);
    wr_reg(`CARF_OFF_FILT0 + 8'h10, 32'h0aa0);
    wr_reg(`CARF_OFF_BPTR0, 32'h02ba);
    wr_reg(`CARF_OFF_FEN, 32'h1);
    rx(1'b0, 1'b0, 11'h123, 18'h0, 1'b1, 4'ha, 4'h0);
    rx(1'b0, 1'b0, 11'h124, 18'h0, 1'b0, 4'ha, 4'h0);
    rx(1'b1, 1'b0, 11'h123, 18'h0, 1'b0, 4'ha, 4'h0);
    rx(1'b1, 1'b0, 11'h123, 18'h1234, 1'b1, 4'ha, 4'h0);
    wr_reg(`CARF_OFF_FEN, 32'h0);
    rx(1'b0, 1'b0, 11'h123, 18'h0, 1'b0, 4'ha, 4'h0);
    wr_reg(`CARF_OFF_FEN, 32'h3);
    rx_buf_full <= 16'h0400;
    rx(1'b0, 1'b0, 11'h123, 18'h0, 1'b1, 4'hb, 4'h1);
    rx_buf_full <= 16'h0000;
    wr_reg(`CARF_OFF_FEN, 32'h1);
    wr_reg(`CARF_OFF_MASK0 + 8'h10, 32'hffc0);
    for (int c = 0; c < 4; c++) begin
      wr_reg(`CARF_OFF_MSEL_LO, c);
      rx(1'b0, 1'b0, 11'h122, 18'h0, msk_hit[c], 4'ha, 4'h0);
    end
    wr_reg(`CARF_OFF_MSEL_LO, 32'h1);
    wr_reg(`CARF_OFF_MASK0 + 8'h08, 32'h8);
    rx(1'b1, 1'b0, 11'h123, 18'h5, 1'b0, 4'ha, 4'h0);
    rx(1'b0, 1'b0, 11'h123, 18'h0, 1'b1, 4'ha, 4'h0);
    wr_reg(`CARF_OFF_FILT0, 32'h2468);
    rx(1'b1, 1'b0, 11'h123, 18'h5, 1'b1, 4'ha, 4'h0);
    wr_reg(`CARF_OFF_MASK0 + 8'h08, 32'h0);
    rx(1'b0, 1'b0, 11'h123, 18'h0, 1'b1, 4'ha, 4'h0);
    wr_reg(`CARF_OFF_FEN, 32'h4);
    wr_reg(`CARF_OFF_BPC0 + 8'h04, 32'h80);
    rx(1'b0, 1'b1, 11'h055, 18'h0, 1'b0, 4'h2, 4'h2);
    chk("send_pending", 8'h00, send_pending);
    wr_reg(`CARF_OFF_BPC0 + 8'h04, 32'h84);
    rx(1'b0, 1'b1, 11'h055, 18'h0, 1'b0, 4'h2, 4'h2);
    chk("send_pending", 8'h04, send_pending);
    node.start(3'h2);
    wr_reg(`CARF_OFF_BPC0 + 8'h04, 32'h80);
    chk("send_pending", 8'h04, send_pending);
    node.done(1'b1);
    @(negedge aclk);
    chk("send_pending", 8'h00, send_pending);
    wr_reg(`CARF_OFF_BPC0, 32'h8b8a);
    chk("send_pending", 8'h03, send_pending);
    chk("tx_priority", 16'h000e, tx_priority);
    node.start(3'h1);
    wr_reg(`CARF_OFF_CTRL, 32'h1000);
    rd_reg(`CARF_OFF_STAT);
    chk("status", 32'h543, rd);
    chk("send_pending", 8'h02, send_pending);
    node.done(1'b1);
    @(negedge aclk);
    chk("send_pending", 8'h00, send_pending);
    wr_reg(`CARF_OFF_BPC0 + 8'h08, 32'h08);
    chk("send_pending", 8'h00, send_pending);
    wr_reg(`CARF_OFF_BPC0 + 8'h08, 32'h88);
    chk("send_pending", 8'h10, send_pending);
    wr_reg(`CARF_OFF_BPC0 + 8'h08, 32'h80);
    chk("send_pending", 8'h00, send_pending);
    wstrb <= 4'h2;
    wr_reg(`CARF_OFF_BPC0 + 8'h08, 32'h8800);
    chk("send_pending", 8'h20, send_pending);
    results();
  end
endmodule

// File: sim/carf_node.sv
`timescale 1ns/1ps
module carf_node (
  input  wire logic   aclk,
  output logic        rx_valid,
  output logic        rx_ide,
  output logic        rx_rtr,
  output logic [10:0] rx_sid,
  output logic [17:0] rx_eid,
  output logic        tx_start,
  output logic [2:0]  tx_start_idx,
  output logic        tx_done,
  output logic        tx_done_ok
);
  // ----------------------------------------------------------------
  // Far-side node and transmit engine
  // ----------------------------------------------------------------
  // Quiet lines start low, then show the inverse of the last value.
  initial begin
    {rx_valid, rx_ide, rx_rtr, tx_start, tx_done, tx_done_ok} = '0;
    {rx_sid, rx_eid, tx_start_idx} = '0;
  end
  task automatic frame(input logic ide, input logic rtr, input logic [10:0] sid, input logic [17:0] eid);
    @(posedge aclk);
    rx_valid <= 1'b1;
    {rx_ide, rx_rtr, rx_sid, rx_eid} <= {ide, rtr, sid, eid};
    @(posedge aclk);
    rx_valid <= 1'b0;
    {rx_ide, rx_rtr, rx_sid, rx_eid} <= ~{ide, rtr, sid, eid};
  endtask
  // The engine reports the buffer it put on the bus.
  task automatic start(input logic [2:0] idx);
    @(posedge aclk);
    {tx_start, tx_start_idx} <= {1'b1, idx};
    @(posedge aclk);
    {tx_start, tx_start_idx} <= {1'b0, ~idx};
  endtask
  task automatic done(input logic ok);
    @(posedge aclk);
    {tx_done, tx_done_ok} <= {1'b1, ok};
    @(posedge aclk);
    {tx_done, tx_done_ok} <= {1'b0, ~ok};
  endtask
endmodule

// File: sim/carf_sva.sv
`timescale 1ns/1ps
`include "carf_map.svh"
module carf_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [7:0]  awaddr,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [31:0] wdata,
  input wire logic        rx_valid,
  input wire logic [15:0] rx_buf_full,
  input wire logic        tx_start,
  input wire logic [2:0]  tx_start_idx,
  input wire logic        tx_done,
  input wire logic        tx_done_ok,
  input wire logic [7:0]  send_pending,
  input wire logic        dma_req,
  input wire logic        dma_ack,
  input wire logic [3:0]  dma_buf,
  input wire logic [3:0]  dma_filter,
  input wire logic [7:0]  dma_word_base
);
  import carf_pkg::*;
  logic        busy_h;
  logic [2:0]  idx_h;
  logic [15:0] full_q;
  logic [7:0]  busy_mask;
  // ----------------------------------------------------------------
  // Helper state and checks
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Follow the engine strobes, since the frame on the bus is not a port.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_h <= 1'b0;
      idx_h  <= 3'h0;
      full_q <= 16'h0000;
    end else begin
      full_q <= rx_buf_full;
      if (tx_start) begin
        busy_h <= 1'b1;
        idx_h  <= tx_start_idx;
      end else if (tx_done) begin
        busy_h <= 1'b0;
      end
    end
  end
  assign busy_mask = busy_h ? (8'h01 << idx_h) : 8'h00;
  chk_word_base: assert property (dma_req |-> dma_word_base == {1'b0, dma_buf, 3'b000})
    else $error("dma word base is not buffer times eight");
  chk_req_hold: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_buf) && $stable(dma_filter))
    else $error("dma request dropped or changed before ack");
  chk_req_cause: assert property ($rose(dma_req) |-> $past(rx_valid, 2))
    else $error("dma request without a frame two cycles before");
  chk_req_release: assert property (dma_req && dma_ack && !$past(rx_valid) && !rx_valid |=> !dma_req)
    else $error("dma request stayed after ack");
  chk_empty_slot: assert property ($rose(dma_req) |-> dma_buf == 4'hf || !full_q[dma_buf])
    else $error("message sent to a full buffer");
  chk_done_clears: assert property (tx_done && tx_done_ok && busy_h |=> !send_pending[idx_h])
    else $error("send request kept after good transmission");
  chk_busy_kept: assert property (busy_h && send_pending[idx_h] && !tx_done |=> send_pending[idx_h])
    else $error("frame on the bus lost its send request");
  chk_abort_all: assert property (awvalid && awready && wvalid && wready && awaddr == `CARF_OFF_CTRL
    && wdata[`CARF_BIT_ABORT] |-> ##[1:3] (send_pending & ~busy_mask) == 8'h00)
    else $error("idle send requests survived abort all");
  cov_dma: cover property ($rose(dma_req));
  cov_answer: cover property ($rose(send_pending[2]) && !busy_h);
  cov_done: cover property (tx_done && tx_done_ok && busy_h);
endmodule
bind carf_top carf_sva u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .rx_valid(rx_valid),
  .rx_buf_full(rx_buf_full), .tx_start(tx_start), .tx_start_idx(tx_start_idx), .tx_done(tx_done),
  .tx_done_ok(tx_done_ok), .send_pending(send_pending), .dma_req(dma_req), .dma_ack(dma_ack),
  .dma_buf(dma_buf), .dma_filter(dma_filter), .dma_word_base(dma_word_base));
